// ---- inc/lcdcs_map.vh ----
// Purpose: register map, field positions and reset values of the common scan block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes:   display-method word bit i holds instruction data bit 240+i
`ifndef LCDCS_MAP_VH
`define LCDCS_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define LCDCS_METHOD_OFS      8'h00
`define LCDCS_CONTROL_OFS     8'h04
`define LCDCS_LINE_OFS        8'h08
`define LCDCS_STATUS_OFS      8'h0C

////////////////////////////////////////////////////////////////////////////////
// display-method word fields
`define LCDCS_CLK_EXT_BIT     0
`define LCDCS_BOOST_RUN_BIT   4
`define LCDCS_CONTRAST_BIT    5
`define LCDCS_BIASGEN_BIT     6
`define LCDCS_DUTY_LO         8
`define LCDCS_DUTY_HI         11
`define LCDCS_BIAS_RATIO_BIT  12
`define LCDCS_INV_SEL_BIT     13
`define LCDCS_SCAN_REV_BIT    16

////////////////////////////////////////////////////////////////////////////////
// control and status fields
`define LCDCS_PSAVE_BIT       0
`define LCDCS_ST_VALID_BIT    0
`define LCDCS_ST_PEND_BIT     1
`define LCDCS_ST_ROW_LO       4
`define LCDCS_ST_ROW_HI       7
`define LCDCS_ST_ROWS_LO      8
`define LCDCS_ST_ROWS_HI      12
`define LCDCS_ST_REV_BIT      13
`define LCDCS_ST_BIAS5_BIT    14
`define LCDCS_ST_FINV_BIT     15
`define LCDCS_ST_POL_BIT      16
`define LCDCS_ST_CONTRAST_BIT 17
`define LCDCS_ST_BIASGEN_BIT  18

////////////////////////////////////////////////////////////////////////////////
// reset values and counts
`define LCDCS_METHOD_RST      32'h0000_0000
`define LCDCS_LINE_RST        16'h0010
`define LCDCS_LINE_MIN        16'h0001
`define LCDCS_ROWS_BASE       5'h08
`define LCDCS_ROWS_FULL       5'h10

`endif

// ---- hdl/lcdcs_duty_dec.v ----
// Purpose: duty field to scanned row count and display-off mask
// Assumes: combinational, driven from the active settings
// Notes:   bit k of off_mask stands for common k+1
`timescale 1ns/1ns
`include "lcdcs_map.vh"
module lcdcs_duty_dec (
   // settings
   input  wire [3:0]  duty_select,
   input  wire        common_scan_reverse,
   // decoded
   output reg  [4:0]  rows,
   output reg  [15:0] off_mask
);
   integer k;

   always @* begin
      // top bit forces full duty, others are ignored then
      if (duty_select[3]) begin
         rows = `LCDCS_ROWS_FULL;
      end else begin
         rows = `LCDCS_ROWS_BASE + {2'b00, duty_select[2:0]};
      end
      off_mask = 16'h0000;
      for (k = 0; k < 16; k = k + 1) begin
         if (common_scan_reverse) begin
            // commons 16-N down to 1 idle in reversed scan
            if (k < (16 - rows)) off_mask[k] = 1'b1;
         end else begin
            if (k >= rows) off_mask[k] = 1'b1;
         end
      end
   end
endmodule // lcdcs_duty_dec

// ---- hdl/lcdcs_scan_seq.v ----
// Purpose: row step timer and row index sequencer
// Assumes: line_cycles is never zero
// Notes:   frame_start pulses on the second cycle of run and on each wrap
`timescale 1ns/1ns
`include "lcdcs_map.vh"
module lcdcs_scan_seq (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // control
   input  wire        run,
   input  wire [4:0]  rows,
   input  wire [15:0] line_cycles,
   // sequence
   output reg  [3:0]  row_idx_q,
   output reg         line_step_q,
   output reg         frame_start_q
);
   reg [15:0] timer_q;
   reg        started_q;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         row_idx_q     <= 4'h0;
         line_step_q   <= 1'b0;
         frame_start_q <= 1'b0;
         timer_q       <= 16'h0000;
         started_q     <= 1'b0;
      end else begin
         line_step_q   <= 1'b0;
         frame_start_q <= 1'b0;
         if (!run) begin
            row_idx_q <= 4'h0;
            timer_q   <= 16'h0000;
            started_q <= 1'b0;
         end else if (!started_q) begin
            started_q     <= 1'b1;
            frame_start_q <= 1'b1;
         end else if (timer_q >= line_cycles - `LCDCS_LINE_MIN) begin
            timer_q     <= 16'h0000;
            line_step_q <= 1'b1;
            if ({1'b0, row_idx_q} >= rows - 5'h01) begin
               row_idx_q     <= 4'h0;
               frame_start_q <= 1'b1;
            end else begin
               row_idx_q <= row_idx_q + 4'h1;
            end
         end else begin
            timer_q <= timer_q + 16'h0001;
         end
      end
   end
endmodule // lcdcs_scan_seq

// ---- hdl/lcdcs_top.v ----
// Purpose: display-method decode and common scan control, AHB-Lite slave
// Assumes: single clock hclk, hresetn doubles as the chip clear pad
// Notes:   zero wait states, response always OKAY
`timescale 1ns/1ns
`include "lcdcs_map.vh"
module lcdcs_top (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // common drive
   output reg  [15:0] row_drive_outputs,
   output reg  [15:0] row_off_outputs,
   output reg         drive_polarity,
   // drive mode
   output reg         bias_ratio_select,
   output reg         third_level_unused,
   output reg         inversion_select,
   output reg         clock_external,
   // analog control
   output reg         contrast_adjuster_run,
   output reg         bias_generator_run,
   output reg         contrast_discharge,
   output reg         bias_discharge
);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   reg  [31:0] method_q;
   reg  [31:0] method_d;
   reg         power_save_q;
   reg         power_save_d;
   reg  [15:0] line_q;
   reg  [15:0] line_d;
   reg         valid_q;
   reg         pending_q;

   reg  [3:0]  act_duty_q;
   reg         act_rev_q;
   reg         act_bias5_q;
   reg         act_frame_inv_q;

   reg         wr_pend_q;
   reg  [7:0]  wr_addr_q;
   reg  [31:0] rd_word;

   wire        addr_phase;
   wire        scan_run;
   wire        apply_now;
   wire        method_wr;
   wire [4:0]  rows;
   wire [15:0] off_mask;
   wire [3:0]  row_idx;
   wire        line_step;
   wire        frame_start;
   wire        contrast_ok;
   wire        bias_ok;

   assign addr_phase = hsel & hready & htrans[1];
   assign method_wr  = wr_pend_q & (wr_addr_q == `LCDCS_METHOD_OFS);

   ////////////////////////////////////////////////////////////////////////////////
   // next register values, also used for read-after-write forwarding
   always @* begin
      method_d     = method_q;
      power_save_d = power_save_q;
      line_d       = line_q;
      if (wr_pend_q) begin
         if (wr_addr_q == `LCDCS_METHOD_OFS) begin
            method_d = hwdata;
         end else if (wr_addr_q == `LCDCS_CONTROL_OFS) begin
            power_save_d = hwdata[`LCDCS_PSAVE_BIT];
         end else if (wr_addr_q == `LCDCS_LINE_OFS) begin
            // a zero period would wrap and stretch each row to 65536 cycles
            if (hwdata[15:0] == 16'h0000) begin
               line_d = `LCDCS_LINE_MIN;
            end else begin
               line_d = hwdata[15:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux
   always @* begin
      rd_word = 32'h0000_0000;
      if (haddr == `LCDCS_METHOD_OFS) begin
         rd_word = method_d;
      end else if (haddr == `LCDCS_CONTROL_OFS) begin
         rd_word[`LCDCS_PSAVE_BIT] = power_save_d;
      end else if (haddr == `LCDCS_LINE_OFS) begin
         rd_word[15:0] = line_d;
      end else if (haddr == `LCDCS_STATUS_OFS) begin
         rd_word[`LCDCS_ST_VALID_BIT]                  = valid_q;
         rd_word[`LCDCS_ST_PEND_BIT]                   = pending_q;
         rd_word[`LCDCS_ST_ROW_HI:`LCDCS_ST_ROW_LO]    = row_idx;
         rd_word[`LCDCS_ST_ROWS_HI:`LCDCS_ST_ROWS_LO]  = rows;
         rd_word[`LCDCS_ST_REV_BIT]                    = act_rev_q;
         rd_word[`LCDCS_ST_BIAS5_BIT]                  = act_bias5_q;
         rd_word[`LCDCS_ST_FINV_BIT]                   = act_frame_inv_q;
         rd_word[`LCDCS_ST_POL_BIT]                    = drive_polarity;
         rd_word[`LCDCS_ST_CONTRAST_BIT]               = contrast_adjuster_run;
         rd_word[`LCDCS_ST_BIASGEN_BIT]                = bias_generator_run;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         // never stalls, never errors; unmapped reads give zero
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_q <= addr_phase & hwrite;
         if (addr_phase) begin
            wr_addr_q <= haddr;
         end
         if (addr_phase & ~hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // software registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         method_q     <= `LCDCS_METHOD_RST;
         power_save_q <= 1'b0;
         line_q       <= `LCDCS_LINE_RST;
         valid_q      <= 1'b0;
      end else begin
         method_q     <= method_d;
         power_save_q <= power_save_d;
         line_q       <= line_d;
         // scan waits until the first method word is active, so no row shows reset settings
         if (apply_now) begin
            valid_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shadow to active settings
   assign scan_run  = valid_q & ~power_save_q;
   assign apply_now = pending_q & (frame_start | ~scan_run);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pending_q       <= 1'b0;
         act_duty_q      <= 4'h0;
         act_rev_q       <= 1'b0;
         act_bias5_q     <= 1'b0;
         act_frame_inv_q <= 1'b0;
      end else begin
         // a fresh write wins over the apply in the same cycle
         if (method_wr) begin
            pending_q <= 1'b1;
         end else if (apply_now) begin
            pending_q <= 1'b0;
         end
         // switching mid-frame would cut the scan short
         if (apply_now) begin
            act_duty_q      <= method_q[`LCDCS_DUTY_HI:`LCDCS_DUTY_LO];
            act_rev_q       <= method_q[`LCDCS_SCAN_REV_BIT];
            act_bias5_q     <= method_q[`LCDCS_BIAS_RATIO_BIT];
            act_frame_inv_q <= method_q[`LCDCS_INV_SEL_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // duty decode and row sequencer
   lcdcs_duty_dec u_duty (
      .duty_select         (act_duty_q),
      .common_scan_reverse (act_rev_q),
      .rows                (rows),
      .off_mask            (off_mask)
   );

   lcdcs_scan_seq u_seq (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .run           (scan_run),
      .rows          (rows),
      .line_cycles   (line_q),
      .row_idx_q     (row_idx),
      .line_step_q   (line_step),
      .frame_start_q (frame_start)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // common outputs
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         row_drive_outputs <= 16'h0000;
         row_off_outputs   <= 16'h0000;
         drive_polarity    <= 1'b0;
      end else begin
         if (!scan_run) begin
            // stopped scan drives nothing, polarity restarts
            row_drive_outputs <= 16'h0000;
            row_off_outputs   <= 16'h0000;
            drive_polarity    <= 1'b0;
         end else begin
            row_off_outputs   <= off_mask;
            row_drive_outputs <= 16'h0000;
            if (act_rev_q) begin
               row_drive_outputs[4'hF - row_idx] <= 1'b1;
            end else begin
               row_drive_outputs[row_idx] <= 1'b1;
            end
            if (act_frame_inv_q) begin
               if (frame_start) drive_polarity <= ~drive_polarity;
            end else begin
               if (line_step) drive_polarity <= ~drive_polarity;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // drive mode outputs
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bias_ratio_select  <= 1'b0;
         third_level_unused <= 1'b1;
         inversion_select   <= 1'b0;
         clock_external     <= 1'b0;
      end else begin
         bias_ratio_select  <= act_bias5_q;
         third_level_unused <= ~act_bias5_q;
         inversion_select   <= act_frame_inv_q;
         clock_external     <= method_q[`LCDCS_CLK_EXT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // contrast adjuster and bias generator
   // power save overrides any set run bit for both circuits
   assign contrast_ok = method_q[`LCDCS_CONTRAST_BIT] & ~power_save_q;
   assign bias_ok     = method_q[`LCDCS_BIASGEN_BIT] & ~power_save_q;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // reset holds both stopped and discharged
         contrast_adjuster_run <= 1'b0;
         bias_generator_run    <= 1'b0;
         contrast_discharge    <= 1'b1;
         bias_discharge        <= 1'b1;
      end else begin
         contrast_adjuster_run <= contrast_ok;
         bias_generator_run    <= bias_ok;
         contrast_discharge    <= ~contrast_ok;
         bias_discharge        <= ~bias_ok;
      end
   end

endmodule // lcdcs_top

// ---- bench/lcdcs_monitor.sv ----
// Purpose: port-level checks of the common scan block
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to lcdcs_top, sees its ports only
`timescale 1ns/1ns
module lcdcs_monitor (
   // clock and reset
   input wire        hclk,
   input wire        hresetn,
   // bus answer
   input wire        hreadyout,
   input wire        hresp,
   // common drive
   input wire [15:0] row_drive_outputs,
   input wire [15:0] row_off_outputs,
   // mode and analog
   input wire        bias_ratio_select,
   input wire        third_level_unused,
   input wire        contrast_adjuster_run,
   input wire        bias_generator_run,
   input wire        contrast_discharge,
   input wire        bias_discharge
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire [15:0] inv_off = ~row_off_outputs;
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_release; $rose(hresetn); endsequence
   sequence s_safe; contrast_discharge && bias_discharge && !contrast_adjuster_run && !bias_generator_run; endsequence
   sequence s_step; $changed(row_drive_outputs) && $past(row_drive_outputs) != 16'h0000 && row_drive_outputs != 16'h0000;
   endsequence
   property p_reset_safe; s_release |-> s_safe; endproperty
   property p_contrast_pair; contrast_discharge != contrast_adjuster_run; endproperty
   property p_biasgen_pair; bias_discharge != bias_generator_run; endproperty
   property p_bias_level; third_level_unused == !bias_ratio_select; endproperty
   property p_one_row; $onehot0(row_drive_outputs); endproperty
   property p_disjoint; (row_drive_outputs & row_off_outputs) == 16'h0000; endproperty
   // off commons form one block at either end, never more than 8 of them
   property p_off_shape; $countones(row_off_outputs) <= 8 && ((row_off_outputs & (row_off_outputs + 16'h0001)) == 16'h0000
      || (inv_off & (inv_off + 16'h0001)) == 16'h0000); endproperty
   property p_step; s_step |-> row_drive_outputs == ($past(row_drive_outputs) << 1) || row_drive_outputs ==
      ($past(row_drive_outputs) >> 1) || row_drive_outputs == 16'h0001 || row_drive_outputs == 16'h8000; endproperty
   property p_bus_okay; hreadyout && !hresp; endproperty
   a_reset_safe: assert property (p_reset_safe) else $error("circuits live after reset release");
   a_contrast_pair: assert property (p_contrast_pair) else $error("contrast run and discharge disagree");
   a_biasgen_pair: assert property (p_biasgen_pair) else $error("bias run and discharge disagree");
   a_bias_level: assert property (p_bias_level) else $error("third level flag wrong");
   a_one_row: assert property (p_one_row) else $error("more than one common scanned");
   a_disjoint: assert property (p_disjoint) else $error("scanned common marked off");
   a_off_shape: assert property (p_off_shape) else $error("off commons not one end block");
   a_step: assert property (p_step) else $error("scan skipped a common");
   a_bus_okay: assert property (p_bus_okay) else $error("bus wait or error seen");
endmodule // lcdcs_monitor

bind lcdcs_top lcdcs_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .row_drive_outputs(row_drive_outputs), .row_off_outputs(row_off_outputs),
   .bias_ratio_select(bias_ratio_select), .third_level_unused(third_level_unused),
   .contrast_adjuster_run(contrast_adjuster_run), .bias_generator_run(bias_generator_run),
   .contrast_discharge(contrast_discharge), .bias_discharge(bias_discharge));

// ---- bench/lcdcs_host.sv ----
// Purpose: host model, single-word bus master
// Assumes: one slave, its hreadyout is hready
// Notes:   waits have no bound here, the bench timeout cuts a hang
`timescale 1ns/1ns
module lcdcs_host (
   // clock and answer
   input  wire        hclk,
   input  wire        hready,
   input  wire [31:0] hrdata,
   // request
   output logic       hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic       hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b0; haddr = 8'h00; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0000_0000;
   end
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00; hsel <= 1'b0; hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
      // released data no longer shows the word
      hwdata <= ~d; haddr <= ~a;
   endtask
endmodule // lcdcs_host

// ---- bench/lcdcs_top_tb.sv ----
// Purpose: self-checking bench of the common scan block
// Assumes: LINE shortened to 2 clocks per common
// Notes:   method words random, duty swept 0..15 first
`timescale 1ns/1ns
`include "lcdcs_map.vh"
module lcdcs_top_tb;
   logic hclk = 1'b0, hresetn = 1'b0;
   wire hsel, hwrite, hreadyout, hresp, pol, bsel, tlu, isel, cext, crun, brun, cdis, bdis;
   wire [7:0] haddr;
   wire [1:0] htrans;
   wire [2:0] hsize;
   wire [31:0] hwdata, hrdata;
   wire [15:0] rows, offs;
   int n_mismatch = 0, samples_checked = 0, cyc = 0;
   logic [31:0] m, r;
   logic [15:0] om;
   int n, p, pp, st;
   logic ppol;
   ////////////////////////////////////////////////////////////////////////////////
   lcdcs_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   lcdcs_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .row_drive_outputs(rows), .row_off_outputs(offs), .drive_polarity(pol), .bias_ratio_select(bsel),
      .third_level_unused(tlu), .inversion_select(isel), .clock_external(cext), .contrast_adjuster_run(crun),
      .bias_generator_run(brun), .contrast_discharge(cdis), .bias_discharge(bdis));
   initial forever #5 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      i_host.xfer(a, 1'b1, d, x);
   endtask
   function automatic int rows_of(logic [3:0] dt);
      return dt[3] ? 16 : 8 + dt;
   endfunction
   function automatic logic [15:0] offm(logic [3:0] dt, logic rv);
      logic [15:0] one = 16'h0001 << rows_of(dt);
      return rv ? (16'h0001 << (16 - rows_of(dt))) - 16'h0001 : ~(one - 16'h0001);
   endfunction
   function automatic int nxt(int q, int k, logic rv);
      return rv ? (q == 16 - k ? 15 : q - 1) : (q == k - 1 ? 0 : q + 1);
   endfunction
   task reset_check(input string name);
      @(negedge hclk);
      chk({rows, offs}, 32'h0000_0000);
      chk({cdis, bdis, crun, brun, tlu, hreadyout}, 32'h0000_0033);
      $display("test %s done", name);
   endtask
   task finish_test();
      $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(26530));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      reset_check("reset");
      m = 32'h0000_0000;
      wr(`LCDCS_METHOD_OFS, m);
      i_host.xfer(`LCDCS_LINE_OFS, 1'b0, 32'h0, r);
      chk(r, 32'h0000_0010);
      wr(`LCDCS_LINE_OFS, 32'h0000_0000);
      i_host.xfer(`LCDCS_LINE_OFS, 1'b0, 32'h0, r);
      chk(r, 32'h0000_0001);
      i_host.xfer(8'h40, 1'b0, 32'h0, r);
      chk(r, 32'h0000_0000);
      wr(`LCDCS_LINE_OFS, 32'h0000_0002);
      for (int i = 0; i < 26; i++) begin
         om = offm(m[11:8], m[16]);
         // start a write just after a frame begins, so a pending word is visible
         do @(negedge hclk); while (rows !== (m[16] ? 16'h8000 : 16'h0001));
         m = ($urandom & 32'h0001_3061) | ((i < 16 ? i : $urandom) & 15) << 8;
         wr(`LCDCS_METHOD_OFS, m);
         @(negedge hclk);
         chk(offs, om);
         repeat (70) @(negedge hclk);
         n = rows_of(m[11:8]);
         chk(offs, offm(m[11:8], m[16]));
         chk({bsel, tlu, isel, cext}, {m[12], ~m[12], m[13], m[0]});
         chk({crun, brun}, {m[5], m[6]});
         pp = -1; st = 0; ppol = pol;
         for (int c = 0; c < 4 * n + 4; c++) begin
            @(negedge hclk);
            p = -1;
            for (int b = 0; b < 16; b++) if (rows[b] === 1'b1) p = b;
            if (pp >= 0) chk(pol ^ ppol, (p != pp) && (!m[13] || p == (m[16] ? 15 : 0)));
            if (pp >= 0 && p != pp) begin
               chk(p, nxt(pp, n, m[16]));
               st++;
            end
            pp = p;
            ppol = pol;
         end
         chk(st >= n, 1'b1);
         $display("test duty%0d done", i);
      end
      m = m | 32'h0000_0060;
      wr(`LCDCS_METHOD_OFS, m);
      wr(`LCDCS_CONTROL_OFS, 32'h0000_0001);
      repeat (3) @(negedge hclk);
      chk({crun, brun, cdis, bdis, rows}, 32'h0003_0000);
      wr(`LCDCS_CONTROL_OFS, 32'h0000_0000);
      repeat (3) @(negedge hclk);
      chk({crun, brun}, 32'h0000_0003);
      @(posedge hclk);
      hresetn <= 1'b0;
      reset_check("midrun reset");
      @(posedge hclk);
      hresetn <= 1'b1;
      // no method word yet: scan stays stopped, circuits stay discharged
      repeat (3) @(negedge hclk);
      chk({rows, offs}, 32'h0000_0000);
      chk({cdis, bdis, crun, brun}, 32'h0000_000C);
      finish_test();
   end
endmodule // lcdcs_top_tb
